// ===== shared/sfb_pkg.sv
// package: register map, field positions, reset values and event carrier
// What this block does
// [R1] summary bit 7 ORs every flag
// [R2] summary bits 6..3 OR each flag register
// [R3] event flags reset zero, write one clears
// [R4] watchdog flag sets on every watchdog error
// [R5] wake error sets on timer expiry to sleep
// [R6] event flag bits 3 and 1 read zero
// [R7] supply flags reset with power-on flag set
// [R8] supply/thermal flags write one clears
// [R9] serial error flag follows serial status error
// [R10] bus fault flags 5..2 write one clears
// [R11] bits 1/0 flag shorts to ground/battery
// [R12] bus fault bits 7..6 read zero
// [R13] event mask read-write, resets F3h
// [R14] supply mask read-write, resets 3Fh
// [R15] serial mask bit 7 resets set
// [R16] bus fault mask bits 5..0, resets 7Fh
// [R17] reserved range 5Ah..5Fh reads zero
// [R18] summary computed combinationally from flags
package sfb_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] SFB_IDX_SUMMARY   = 8'h50;
  localparam logic [7:0] SFB_IDX_EVT_FLAGS = 8'h51;
  localparam logic [7:0] SFB_IDX_SUP_FLAGS = 8'h52;
  localparam logic [7:0] SFB_IDX_SER_FLAGS = 8'h53;
  localparam logic [7:0] SFB_IDX_BUS_FLAGS = 8'h54;
  localparam logic [7:0] SFB_IDX_EVT_MASK  = 8'h56;
  localparam logic [7:0] SFB_IDX_SUP_MASK  = 8'h57;
  localparam logic [7:0] SFB_IDX_SER_MASK  = 8'h58;
  localparam logic [7:0] SFB_IDX_BUS_MASK  = 8'h59;
  localparam logic [7:0] SFB_IDX_RSVD_LO   = 8'h5A;
  localparam logic [7:0] SFB_IDX_RSVD_HI   = 8'h5F;

  // implemented-bit masks of each flag register
  localparam logic [7:0] SFB_EVT_BITS = 8'hF5;
  localparam logic [7:0] SFB_SUP_BITS = 8'h77;
  localparam logic [7:0] SFB_SER_BITS = 8'h80;
  localparam logic [7:0] SFB_BUS_BITS = 8'h3F;

  // reset values
  localparam logic [7:0] SFB_EVT_FLAGS_RST = 8'h00;
  localparam logic [7:0] SFB_SUP_FLAGS_RST = 8'h40;
  localparam logic [7:0] SFB_SER_FLAGS_RST = 8'h00;
  localparam logic [7:0] SFB_BUS_FLAGS_RST = 8'h00;
  localparam logic [7:0] SFB_EVT_MASK_RST  = 8'hF3;
  localparam logic [7:0] SFB_SUP_MASK_RST  = 8'h3F;
  localparam logic [7:0] SFB_SER_MASK_RST  = 8'h80;
  localparam logic [7:0] SFB_BUS_MASK_RST  = 8'h7F;
  // writable bits of each mask register
  localparam logic [7:0] SFB_EVT_MASK_BITS = 8'hF5;
  localparam logic [7:0] SFB_SUP_MASK_BITS = 8'h37;
  localparam logic [7:0] SFB_SER_MASK_BITS = 8'h80;
  localparam logic [7:0] SFB_BUS_MASK_BITS = 8'h3F;

  // field positions
  localparam int SFB_B_WATCHDOG   = 7;
  localparam int SFB_B_BUS_WAKE   = 6;
  localparam int SFB_B_LOCAL_WAKE = 5;
  localparam int SFB_B_WAKE_ERR   = 4;
  localparam int SFB_B_SILENT     = 2;
  localparam int SFB_B_STUCK_DOM  = 0;
  localparam int SFB_B_POWER_ON   = 6;
  localparam int SFB_B_REG_OV     = 5;
  localparam int SFB_B_IN_UV      = 4;
  localparam int SFB_B_REG_UV     = 2;
  localparam int SFB_B_TSD        = 1;
  localparam int SFB_B_THERMAL_WARNING       = 0;
  localparam int SFB_B_SERIAL     = 7;
  localparam int SFB_B_SHORTED    = 5;
  localparam int SFB_B_H_BAT      = 4;
  localparam int SFB_B_L_GND      = 3;
  localparam int SFB_B_OPEN       = 2;
  localparam int SFB_B_BUS_GND    = 1;
  localparam int SFB_B_BUS_BAT    = 0;
  localparam int SFB_B_ANY        = 7;
  localparam int SFB_B_SUM_EVT    = 6;
  localparam int SFB_B_SUM_SUP    = 5;
  localparam int SFB_B_SUM_SER    = 4;
  localparam int SFB_B_SUM_BUS    = 3;

  // asynchronous event levels from the sources
  typedef struct packed {
    logic watchdog_event;
    logic bus_wake;
    logic local_wake;
    logic wake_timer_expired;
    logic in_sleep;
    logic bus_silent;
    logic stuck_dominant;
    logic regulator_overvoltage;
    logic input_undervoltage;
    logic regulator_undervoltage;
    logic thermal_shutdown;
    logic thermal_warning;
    logic serial_error;
    logic lines_shorted;
    logic high_to_battery;
    logic low_to_ground;
    logic bus_open;
    logic bus_to_ground;
    logic bus_to_battery;
  } sfb_events_t;

  // decoded register write
  typedef struct packed {
    logic       wr;
    logic [7:0] idx;
    logic [7:0] data;
  } sfb_wr_t;
endpackage

// ===== design/sfb_flag_reg.sv
// one sticky write-one-to-clear flag register with its enable mask
`timescale 1ns/1ps
module sfb_flag_reg #(
  parameter logic [7:0] FLAG_IDX  = 8'h00,
  parameter logic [7:0] MASK_IDX  = 8'h00,
  parameter logic [7:0] FLAG_BITS = 8'h00,
  parameter logic [7:0] FLAG_RST  = 8'h00,
  parameter logic [7:0] MASK_BITS = 8'h00,
  parameter logic [7:0] MASK_RST  = 8'h00
) (
  // clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // register write and hardware set
  input  wire sfb_pkg::sfb_wr_t wr,
  input  wire logic [7:0]     set,
  // state
  output logic [7:0]          flags_r,
  output logic [7:0]          mask_r
);
  import sfb_pkg::*;

  // set wins over a simultaneous write-one clear; reserved bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= FLAG_RST;
    end else begin
      flags_r <= ((flags_r & ~((wr.wr && wr.idx == FLAG_IDX) ? wr.data : 8'h00)) | set)
                 & FLAG_BITS;
    end
  end

  // enables are plain read-write over implemented bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= MASK_RST;
    end else if (wr.wr && wr.idx == MASK_IDX) begin
      mask_r <= wr.data & MASK_BITS;
    end
  end
endmodule // sfb_flag_reg

// ===== design/sfb_sync.sv
// two-flop synchroniser for a bus of asynchronous event levels
`timescale 1ns/1ps
module sfb_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // levels
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // sfb_sync

// ===== design/sfb_flag_bank.sv
// interrupt flag and mask bank with APB slave and interrupt output
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module sfb_flag_bank (
  // apb clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // asynchronous event levels from the analog and mode logic
  input  wire sfb_pkg::sfb_events_t events,
  // interrupt
  output logic                      irq
);
  import sfb_pkg::*;

  localparam int NEV = $bits(sfb_events_t);

  sfb_events_t ev_s;
  sfb_events_t ev_d_r;
  sfb_events_t ev_rise;
  sfb_wr_t     wr;
  logic [7:0]  set_evt, set_sup, set_ser, set_bus;
  logic [7:0]  evt_f, sup_f, ser_f, bus_f;
  logic [7:0]  evt_m, sup_m, ser_m, bus_m;
  logic [7:0]  summary;
  logic [7:0]  rd_byte;
  logic        access;
  logic        addr_ok;

  // event levels arrive from another domain
  sfb_sync #(.W(NEV)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (events),
    .q       (ev_s)
  );

  // rising edges: a held fault sets its flag once, not again after clearing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_d_r <= '0;
    end else begin
      ev_d_r <= ev_s;
    end
  end
  assign ev_rise = ev_s & ~ev_d_r;

  // map event edges onto flag positions
  always_comb begin
    set_evt = 8'h00;
    set_sup = 8'h00;
    set_ser = 8'h00;
    set_bus = 8'h00;
    set_evt[SFB_B_WATCHDOG]   = ev_rise.watchdog_event;                 // [R4]
    set_evt[SFB_B_BUS_WAKE]   = ev_rise.bus_wake;                       // [R3]
    set_evt[SFB_B_LOCAL_WAKE] = ev_rise.local_wake;                     // [R3]
    set_evt[SFB_B_WAKE_ERR]   = ev_rise.wake_timer_expired & ev_s.in_sleep; // [R5]
    set_evt[SFB_B_SILENT]     = ev_rise.bus_silent;                     // [R3]
    set_evt[SFB_B_STUCK_DOM]  = ev_rise.stuck_dominant;                 // [R3]
    set_sup[SFB_B_REG_OV]     = ev_rise.regulator_overvoltage;          // [R8]
    set_sup[SFB_B_IN_UV]      = ev_rise.input_undervoltage;             // [R8]
    set_sup[SFB_B_REG_UV]     = ev_rise.regulator_undervoltage;         // [R8]
    set_sup[SFB_B_TSD]        = ev_rise.thermal_shutdown;               // [R8]
    set_sup[SFB_B_THERMAL_WARNING]       = ev_rise.thermal_warning;                // [R8]
    set_ser[SFB_B_SERIAL]     = ev_rise.serial_error;                   // [R9]
    set_bus[SFB_B_SHORTED]    = ev_rise.lines_shorted;                  // [R10]
    set_bus[SFB_B_H_BAT]      = ev_rise.high_to_battery;                // [R10]
    set_bus[SFB_B_L_GND]      = ev_rise.low_to_ground;                  // [R10]
    set_bus[SFB_B_OPEN]       = ev_rise.bus_open;                       // [R10]
    set_bus[SFB_B_BUS_GND]    = ev_rise.bus_to_ground;                  // [R11]
    set_bus[SFB_B_BUS_BAT]    = ev_rise.bus_to_battery;                 // [R11]
  end

  // apb decode: zero-wait access phase, word index from byte address
  assign access  = psel && penable;
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign wr.wr   = access && pwrite && addr_ok;
  assign wr.idx  = paddr[9:2];
  assign wr.data = pwdata[7:0];

  // flag registers and their masks
  sfb_flag_reg #(.FLAG_IDX(SFB_IDX_EVT_FLAGS), .MASK_IDX(SFB_IDX_EVT_MASK),
    .FLAG_BITS(SFB_EVT_BITS), .FLAG_RST(SFB_EVT_FLAGS_RST),
    .MASK_BITS(SFB_EVT_MASK_BITS), .MASK_RST(SFB_EVT_MASK_RST)) u_evt (  // [R3] [R6] [R13]
    .pclk(pclk), .presetn(presetn), .wr(wr), .set(set_evt),
    .flags_r(evt_f), .mask_r(evt_m));
  sfb_flag_reg #(.FLAG_IDX(SFB_IDX_SUP_FLAGS), .MASK_IDX(SFB_IDX_SUP_MASK),
    .FLAG_BITS(SFB_SUP_BITS), .FLAG_RST(SFB_SUP_FLAGS_RST),
    .MASK_BITS(SFB_SUP_MASK_BITS), .MASK_RST(SFB_SUP_MASK_RST)) u_sup (  // [R7] [R8] [R14]
    .pclk(pclk), .presetn(presetn), .wr(wr), .set(set_sup),
    .flags_r(sup_f), .mask_r(sup_m));
  sfb_flag_reg #(.FLAG_IDX(SFB_IDX_SER_FLAGS), .MASK_IDX(SFB_IDX_SER_MASK),
    .FLAG_BITS(SFB_SER_BITS), .FLAG_RST(SFB_SER_FLAGS_RST),
    .MASK_BITS(SFB_SER_MASK_BITS), .MASK_RST(SFB_SER_MASK_RST)) u_ser (  // [R9] [R15]
    .pclk(pclk), .presetn(presetn), .wr(wr), .set(set_ser),
    .flags_r(ser_f), .mask_r(ser_m));
  sfb_flag_reg #(.FLAG_IDX(SFB_IDX_BUS_FLAGS), .MASK_IDX(SFB_IDX_BUS_MASK),
    .FLAG_BITS(SFB_BUS_BITS), .FLAG_RST(SFB_BUS_FLAGS_RST),
    .MASK_BITS(SFB_BUS_MASK_BITS), .MASK_RST(SFB_BUS_MASK_RST)) u_bus (  // [R12] [R16]
    .pclk(pclk), .presetn(presetn), .wr(wr), .set(set_bus),
    .flags_r(bus_f), .mask_r(bus_m));

  // summary straight from the flags, no extra storage
  always_comb begin
    summary                = 8'h00;
    summary[SFB_B_SUM_EVT] = |evt_f;                                     // [R2] [R18]
    summary[SFB_B_SUM_SUP] = |sup_f;                                     // [R2]
    summary[SFB_B_SUM_SER] = |ser_f;                                     // [R2]
    summary[SFB_B_SUM_BUS] = |bus_f;                                     // [R2]
    summary[SFB_B_ANY]     = |{evt_f, sup_f, ser_f, bus_f};              // [R1]
  end

  // read mux; reserved range and unknown indices read zero
  always_comb begin
    case (wr.idx)
      SFB_IDX_SUMMARY:   rd_byte = summary;
      SFB_IDX_EVT_FLAGS: rd_byte = evt_f;
      SFB_IDX_SUP_FLAGS: rd_byte = sup_f;
      SFB_IDX_SER_FLAGS: rd_byte = ser_f;
      SFB_IDX_BUS_FLAGS: rd_byte = bus_f;
      SFB_IDX_EVT_MASK:  rd_byte = evt_m;
      SFB_IDX_SUP_MASK:  rd_byte = sup_m;
      SFB_IDX_SER_MASK:  rd_byte = ser_m;
      SFB_IDX_BUS_MASK:  rd_byte = bus_m;
      default:           rd_byte = 8'h00;                                // [R17]
    endcase
  end

  // registered read data, captured in setup so it is valid in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, addr_ok ? rd_byte : 8'h00};
    end
  end

  // ready in the first access cycle of every transfer; misaligned or out-of-window addresses flag an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // level interrupt from any enabled flag; registered, one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |{evt_f & evt_m, sup_f & sup_m, ser_f & ser_m, bus_f & bus_m};
    end
  end

  // checks
  AST_ANY_OR: assert property (@(posedge pclk) disable iff (!presetn)   // [R1]
    summary[7] == (|{evt_f, sup_f, ser_f, bus_f})) else $error("any_fault wrong");
  AST_GROUP_OR: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    summary[2:0] == 3'b000 && summary[6] == |evt_f && summary[3] == |bus_f)
    else $error("group summary wrong");
  AST_WD_SET: assert property (@(posedge pclk) disable iff (!presetn)   // [R4]
    ev_rise.watchdog_event |=> evt_f[7]) else $error("watchdog flag missed");
  AST_WAKE_ERR: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    (ev_rise.wake_timer_expired && ev_s.in_sleep) |=> evt_f[4])
    else $error("wake error missed");
  // mask bit 1 is set by its printed reset value, so only bit 3 of the mask is held at zero
  AST_RSVD_EVT: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    evt_f[3] == 1'b0 && evt_f[1] == 1'b0 && evt_m[3] == 1'b0)
    else $error("reserved event bit set");
  AST_W1C: assert property (@(posedge pclk) disable iff (!presetn)      // [R8]
    (wr.wr && wr.idx == SFB_IDX_SUP_FLAGS && wr.data[1] && !set_sup[1]) |=> !sup_f[1])
    else $error("write one did not clear");
  AST_SERIAL: assert property (@(posedge pclk) disable iff (!presetn)   // [R9]
    ev_rise.serial_error |=> ser_f == 8'h80) else $error("serial flag wrong");
  AST_BUS_GND: assert property (@(posedge pclk) disable iff (!presetn)  // [R11]
    ev_rise.bus_to_ground |=> bus_f[1]) else $error("bus ground flag missed");
  // mask bit 6 is set by its printed reset value; a write must still leave it clear
  AST_BUS_RSVD: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
    bus_f[7:6] == 2'b00 && bus_m[7] == 1'b0) else $error("bus reserved set");
  AST_MASK_WR: assert property (@(posedge pclk) disable iff (!presetn)  // [R16]
    (wr.wr && wr.idx == SFB_IDX_BUS_MASK) |=> bus_m == ($past(wr.data) & SFB_BUS_MASK_BITS))
    else $error("bus mask write wrong");
  AST_RSVD_RD: assert property (@(posedge pclk) disable iff (!presetn)  // [R17]
    (psel && !penable && !pwrite && wr.idx >= SFB_IDX_RSVD_LO && wr.idx <= SFB_IDX_RSVD_HI)
    |=> prdata == 32'h0) else $error("reserved range not zero");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    (|(sup_f & sup_m)) |=> irq) else $error("irq missing");
endmodule // sfb_flag_bank

// ===== tb/sfb_flag_bank_tb_top.sv
// self-checking testbench for the interrupt flag and mask bank
`timescale 1ns/1ps
module sfb_flag_bank_tb_top;
  import sfb_pkg::*;
  logic                pclk      = 1'b0;
  logic                presetn   = 1'b0;
  logic                psel      = 1'b0;
  logic                penable   = 1'b0;
  logic                pwrite    = 1'b0;
  logic [11:0]         paddr     = 12'h000;
  logic [31:0]         pwdata    = 32'h0000_0000;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  sfb_events_t         events    = '0;
  logic                irq;
  int                  miscompares     = 0;
  int                  samples_checked = 0;

  // 40 MHz bus clock
  always #12.5 pclk = ~pclk;

  sfb_flag_bank u_dut (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .events  (events),
    .irq     (irq)
  );

  // verdict in one place, reached by the sequence and the watchdog alike
  task automatic end_sim;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // one apb transfer; the request stands until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, ba(idx), d, r, e);
  endtask

  task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] r;
    logic        er;
    apb(1'b0, ba(idx), 8'h00, r, er);
    chk(nm, {24'h000000, e}, r);
  endtask

  // hold one event level for a few cycles, then let the flag settle
  task automatic pulse(input int k);
    events <= sfb_events_t'(19'h00001 << k);
    repeat (6) @(posedge pclk);
    events <= '0;
    repeat (4) @(posedge pclk);
  endtask

  task automatic irq_chk(input logic e);
    repeat (3) @(posedge pclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  // reset values of every flag, mask and the summary
  task automatic t_reset;
    rchk("evt_flags", SFB_IDX_EVT_FLAGS, 8'h00);
    rchk("sup_flags", SFB_IDX_SUP_FLAGS, 8'h40);
    rchk("ser_flags", SFB_IDX_SER_FLAGS, 8'h00);
    rchk("bus_flags", SFB_IDX_BUS_FLAGS, 8'h00);
    rchk("evt_mask", SFB_IDX_EVT_MASK, 8'hF3);
    rchk("sup_mask", SFB_IDX_SUP_MASK, 8'h3F);
    rchk("ser_mask", SFB_IDX_SER_MASK, 8'h80);
    rchk("bus_mask", SFB_IDX_BUS_MASK, 8'h7F);
    rchk("summary", SFB_IDX_SUMMARY, 8'hA0);
    irq_chk(1'b0);
  endtask

  // clear power-on, write all ones to every flag, mask and reserved index, reserved places stay zero
  task automatic t_write_all;
    logic [31:0] r;
    logic        e;
    for (int i = 8'h51; i <= 8'h54; i++) wr(i[7:0], 8'hFF);
    rchk("sup_cleared", SFB_IDX_SUP_FLAGS, 8'h00);
    rchk("evt_rsvd", SFB_IDX_EVT_FLAGS, 8'h00);
    rchk("bus_rsvd", SFB_IDX_BUS_FLAGS, 8'h00);
    rchk("summary_clear", SFB_IDX_SUMMARY, 8'h00);
    for (int i = 8'h56; i <= 8'h59; i++) wr(i[7:0], 8'hFF);
    rchk("evt_mask_ff", SFB_IDX_EVT_MASK, 8'hF5);
    rchk("sup_mask_ff", SFB_IDX_SUP_MASK, 8'h37);
    rchk("ser_mask_ff", SFB_IDX_SER_MASK, 8'h80);
    rchk("bus_mask_ff", SFB_IDX_BUS_MASK, 8'h3F);
    for (int i = 8'h5A; i <= 8'h5F; i++) begin
      wr(i[7:0], 8'hFF);
      rchk("reserved", i[7:0], 8'h00);
    end
    // misaligned write is refused and leaves the mask alone
    apb(1'b1, ba(SFB_IDX_SER_MASK) | 12'h001, 8'h00, r, e);
    chk("slverr", 32'h1, {31'h0, e});
    rchk("ser_mask_kept", SFB_IDX_SER_MASK, 8'h80);
  endtask

  // where each event lands: {index, bit}
  function automatic logic [15:0] loc(input int k);
    case (k)
      6:       return {SFB_IDX_SER_FLAGS, 8'd7};
      7:       return {SFB_IDX_SUP_FLAGS, 8'd0};
      8:       return {SFB_IDX_SUP_FLAGS, 8'd1};
      9:       return {SFB_IDX_SUP_FLAGS, 8'd2};
      10:      return {SFB_IDX_SUP_FLAGS, 8'd4};
      11:      return {SFB_IDX_SUP_FLAGS, 8'd5};
      12:      return {SFB_IDX_EVT_FLAGS, 8'd0};
      13:      return {SFB_IDX_EVT_FLAGS, 8'd2};
      16:      return {SFB_IDX_EVT_FLAGS, 8'd5};
      17:      return {SFB_IDX_EVT_FLAGS, 8'd6};
      18:      return {SFB_IDX_EVT_FLAGS, 8'd7};
      default: return {SFB_IDX_BUS_FLAGS, 8'(k)};
    endcase
  endfunction

  // every single-source event sets its flag, the summary and irq, then clears
  task automatic t_events;
    logic [15:0] l;
    logic [7:0]  b;
    logic [7:0]  g;
    for (int k = 0; k < 19; k++) begin
      if (k == 14 || k == 15) continue;
      l = loc(k);
      b = 8'h01 << l[7:0];
      g = 8'h08 << (8'h54 - l[15:8]);
      pulse(k);
      rchk("flag_set", l[15:8], b);
      rchk("summary_set", SFB_IDX_SUMMARY, 8'h80 | g);
      chk("irq_set", 32'h1, {31'h0, irq});
      wr(l[15:8], b);
      rchk("flag_clear", l[15:8], 8'h00);
      irq_chk(1'b0);
    end
  endtask

  // wake error only while asleep; watchdog flag sets on every event
  task automatic t_wake_wd;
    pulse(15);
    rchk("wake_awake", SFB_IDX_EVT_FLAGS, 8'h00);
    events <= sfb_events_t'(19'h04000);
    repeat (6) @(posedge pclk);
    events <= sfb_events_t'(19'h0C000);
    repeat (6) @(posedge pclk);
    events <= '0;
    repeat (4) @(posedge pclk);
    rchk("wake_sleep", SFB_IDX_EVT_FLAGS, 8'h10);
    wr(SFB_IDX_EVT_FLAGS, 8'h10);
    for (int i = 0; i < 3; i++) begin
      pulse(18);
      rchk("wd_again", SFB_IDX_EVT_FLAGS, 8'h80);
      wr(SFB_IDX_EVT_FLAGS, 8'h80);
    end
  endtask

  // the mask gates irq but never the flag or summary
  task automatic t_irq_mask;
    pulse(0);
    wr(SFB_IDX_BUS_MASK, 8'h3E);
    irq_chk(1'b0);
    rchk("summary_masked", SFB_IDX_SUMMARY, 8'h88);
    wr(SFB_IDX_BUS_MASK, 8'h01);
    irq_chk(1'b1);
    wr(SFB_IDX_BUS_FLAGS, 8'h01);
    irq_chk(1'b0);
  endtask

  // hang guard, well past the expected run length
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_write_all();
    t_events();
    t_wake_wd();
    t_irq_mask();
    end_sim();
  end
endmodule // sfb_flag_bank_tb_top
